// ### rtl/fsc_ctrl.sv
// Suspend/resume, OTP and status-flag controller of a multi-bank muxed burst flash
// How it works
// - Erase suspend is taken only during block erase, window included.
// - Erase suspend is ignored during chip erase or program.
// - Erase suspend reaches the suspended state within 20 us.
// - Banks not holding the erasing block read array data at once.
// - After recovery, programming any block but the erasing one is allowed.
// - Suspend inside the erase window closes it and suspends at once.
// - Erase-suspended: autoselect and protect of other blocks are accepted.
// - Erase resume continues the erase; suspend/resume addresses are ignored.
// - While programming only program suspend is taken; resume restarts it.
// - Program suspend settles within 2 us; other banks read at once.
// - Other banks read while one writes, except during chip erase.
// - In OTP mode the top 128 words map to the OTP region.
// - Lock status reads 0 unlocked, 1 locked via protection verify.
// - OTP mode lasts until exit, hardware reset; bypass functions off.
// - OTP lock runs over 100 us; hardware reset aborts it; permanent.
// - Lockout supply disables commands and operations and ignores writes.
// - A write needs chip select and write strobe low, output enable high.
// - Reset pin low holds the device; release enters read mode.
// - Burst status reads repeat the first word; restart needs a new address.
// - Status bits: program and erase patterns on five data bits.
// - Suspended blocks report suspend patterns; other blocks read true data.
// - Timeout sets timeout_bit, other flags stay as for the operation.
// - Poll bit is the complement of written data while programming.
// - Toggle bit changes on each read while busy.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl
  import fsc_pkg::*;
#(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Host pins, supply monitor and burst clock
  input wire fsc_pins_s i_pins,
  input wire logic i_burst_clk,
  input wire logic i_hw_rst_n,
  input wire logic i_lockout,
  output logic [15:0] o_adq,
  output logic o_adq_oe,
  // Array side
  output logic [ADDR_W-1:0] o_arr_addr,
  output logic o_arr_otp,
  input wire logic [15:0] i_arr_data,
  output logic o_prot_req,
  output logic [7:0] o_prot_blk,
  output logic o_bypass_en
);
  localparam logic [13:0] WIN_LD = 14'(WIN_CYCLES);
  localparam logic [13:0] LOCK_LD = 14'(LOCK_CYCLES);
  logic rst_q1_r, rst_q2_r;
  wire logic rst_n = rst_q2_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end
  // Pin synchronisers; the first stage feeds only the second
  fsc_async_s as_q1_r, as_q2_r, as_prev_r;
  wire fsc_async_s as_in = '{pins: i_pins, bclk: i_burst_clk, hw_rst_n: i_hw_rst_n, lockout: i_lockout};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      as_q1_r <= '{pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, avd_n: 1'b1, default: '0}, default: '0};
      as_q2_r <= '{pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, avd_n: 1'b1, default: '0}, default: '0};
      as_prev_r <= '{pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, avd_n: 1'b1, default: '0}, default: '0};
    end else begin
      as_q1_r <= as_in;
      as_q2_r <= as_q1_r;
      as_prev_r <= as_q2_r;
    end
  end
  wire fsc_pins_s pin = as_q2_r.pins;
  wire logic hold = !as_q2_r.hw_rst_n || as_q2_r.lockout;
  wire logic avd_lat = !pin.ce_n && !pin.avd_n;
  wire logic wr_go = !pin.ce_n && pin.oe_n && !pin.we_n && as_prev_r.pins.we_n && !hold;
  wire logic rd_go = !pin.ce_n && !pin.oe_n && as_prev_r.pins.oe_n;
  wire logic beat = as_q2_r.bclk && !as_prev_r.bclk && !pin.ce_n && !pin.oe_n;
  wire logic [7:0] cmd = pin.adq[7:0];
  fsc_state_e st_r, st_nxt;
  logic [13:0] tmr_r, tmr_nxt;
  logic es_bg_r, es_bg_nxt;
  logic tmo_r, tmo_nxt;
  logic otp_r, otp_nxt;
  logic lock_r, lock_nxt;
  logic asel_r, asel_nxt;
  logic [ADDR_W-1:0] ers_addr_r, ers_addr_nxt;
  logic [ADDR_W-1:0] prg_addr_r, prg_addr_nxt;
  logic prg_d7_r, prg_d7_nxt;
  logic prot_req_nxt;
  logic [ADDR_W-1:0] rd_addr_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [15:0] op_data_r;
  // AHB-Lite slave
  logic [7:0] ah_addr_r;
  logic ah_wr_r, ah_rd_r;
  wire logic ah_go = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  wire logic ctrl_wr = ah_wr_r && (ah_addr_r == REG_CTRL);
  wire logic sw_prog = ctrl_wr && i_hwdata[CTRL_PROG] && !hold;
  wire logic sw_berase = ctrl_wr && i_hwdata[CTRL_BERASE] && !hold;
  wire logic sw_cerase = ctrl_wr && i_hwdata[CTRL_CERASE] && !hold;
  wire logic sw_done = ctrl_wr && i_hwdata[CTRL_DONE];
  wire logic sw_tmo = ctrl_wr && i_hwdata[CTRL_TMO];
  wire logic [31:0] stat_word = {21'h000000, as_q2_r.lockout, !as_q2_r.hw_rst_n, tmo_r, asel_r, lock_r,
                                 otp_r, es_bg_r, st_r};
  wire logic [31:0] rd_mux = (ah_addr_r == REG_OPADDR) ? {9'h000, op_addr_r} :
                             (ah_addr_r == REG_OPDATA) ? {16'h0000, op_data_r} :
                             (ah_addr_r == REG_STAT) ? stat_word : 32'h00000000;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ah_addr_r <= 8'h00;
      ah_wr_r <= 1'b0;
      ah_rd_r <= 1'b0;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      op_addr_r <= '0;
      op_data_r <= 16'h0000;
    end else begin
      ah_wr_r <= ah_go && i_hwrite;
      ah_rd_r <= ah_go && !i_hwrite;
      if (ah_go) begin
        ah_addr_r <= i_haddr[7:0];
      end
      // Reads take one wait state so read data leaves a flop
      o_hreadyout <= !(ah_go && !i_hwrite);
      if (ah_rd_r) begin
        o_hrdata <= rd_mux;
      end
      if (ah_wr_r && ah_addr_r == REG_OPADDR) begin
        op_addr_r <= i_hwdata[ADDR_W-1:0];
      end
      if (ah_wr_r && ah_addr_r == REG_OPDATA) begin
        op_data_r <= i_hwdata[15:0];
      end
    end
  end
  wire logic [ADDR_W-1:0] pin_addr = {pin.addr_hi, pin.adq};
  wire logic rd_otp = otp_r && (rd_addr_r[ADDR_W-1:OTP_LO] == OTP_TAG);
  wire logic ers_blk_hit = rd_addr_r[BLK_HI:BLK_LO] == ers_addr_r[BLK_HI:BLK_LO];
  wire logic ers_bank_hit = rd_addr_r[BANK_HI:BANK_LO] == ers_addr_r[BANK_HI:BANK_LO];
  wire logic prg_blk_hit = rd_addr_r[BLK_HI:BLK_LO] == prg_addr_r[BLK_HI:BLK_LO];
  wire logic prg_bank_hit = rd_addr_r[BANK_HI:BANK_LO] == prg_addr_r[BANK_HI:BANK_LO];
  wire logic op_in_ers = op_addr_r[BLK_HI:BLK_LO] == ers_addr_r[BLK_HI:BLK_LO];
  wire logic tmr_end = (tmr_r == TMR_ONE);
  // Command and operation sequencing
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r == TMR_ZERO) ? TMR_ZERO : tmr_r - TMR_ONE;
    es_bg_nxt = es_bg_r;
    tmo_nxt = tmo_r;
    otp_nxt = otp_r;
    lock_nxt = lock_r;
    asel_nxt = asel_r;
    ers_addr_nxt = ers_addr_r;
    prg_addr_nxt = prg_addr_r;
    prg_d7_nxt = prg_d7_r;
    prot_req_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (sw_prog) begin
          st_nxt = ST_PROG;
          prg_addr_nxt = op_addr_r;
          prg_d7_nxt = op_data_r[POLL_BIT];
          tmo_nxt = 1'b0;
        end else if (sw_berase) begin
          st_nxt = ST_WIN;
          tmr_nxt = WIN_LD;
          ers_addr_nxt = op_addr_r;
          tmo_nxt = 1'b0;
        end else if (sw_cerase) begin
          st_nxt = ST_CHIP;
          tmo_nxt = 1'b0;
        end else if (wr_go) begin
          if (cmd == CMD_OTP_ENTER) begin
            otp_nxt = 1'b1;
          end else if (cmd == CMD_OTP_EXIT) begin
            otp_nxt = 1'b0;
          end else if (cmd == CMD_AUTOSEL) begin
            asel_nxt = 1'b1;
          end else if (cmd == CMD_RESET) begin
            asel_nxt = 1'b0;
          end else if (cmd == CMD_PROTECT && rd_otp && !lock_r) begin
            st_nxt = ST_LOCK;
            tmr_nxt = LOCK_LD;
          end else if (cmd == CMD_PROTECT) begin
            prot_req_nxt = 1'b1;
          end
        end
      end
      ST_PROG: begin
        if (sw_done) begin
          st_nxt = es_bg_r ? ST_ES : ST_IDLE;
        end else if (wr_go && cmd == CMD_SUSPEND) begin
          st_nxt = ST_PSP;
          tmr_nxt = PSUSP_CYC;
        end
      end
      ST_WIN: begin
        if (sw_berase) begin
          tmr_nxt = WIN_LD;
          ers_addr_nxt = op_addr_r;
        end else if (wr_go && cmd == CMD_SUSPEND) begin
          st_nxt = ST_ES;
          tmr_nxt = TMR_ZERO;
        end else if (wr_go) begin
          st_nxt = ST_IDLE;
        end else if (tmr_end) begin
          st_nxt = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (sw_done) begin
          st_nxt = ST_IDLE;
        end else if (wr_go && cmd == CMD_SUSPEND) begin
          st_nxt = ST_ESP;
          tmr_nxt = ESUSP_CYC;
        end
      end
      ST_CHIP: begin
        if (sw_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_ESP: begin
        if (tmr_end) begin
          st_nxt = ST_ES;
        end
      end
      ST_ES: begin
        if (sw_prog && !op_in_ers) begin
          st_nxt = ST_PROG;
          es_bg_nxt = 1'b1;
          prg_addr_nxt = op_addr_r;
          prg_d7_nxt = op_data_r[POLL_BIT];
        end else if (wr_go) begin
          if (cmd == CMD_RESUME) begin
            st_nxt = ST_ERASE;
            es_bg_nxt = 1'b0;
          end else if (cmd == CMD_AUTOSEL) begin
            asel_nxt = 1'b1;
          end else if (cmd == CMD_RESET) begin
            asel_nxt = 1'b0;
          end else if (cmd == CMD_PROTECT && !ers_blk_hit) begin
            prot_req_nxt = 1'b1;
          end
        end
      end
      ST_PSP: begin
        if (tmr_end) begin
          st_nxt = ST_PS;
        end
      end
      ST_PS: begin
        if (wr_go && cmd == CMD_RESUME) begin
          st_nxt = ST_PROG;
        end
      end
      ST_LOCK: begin
        if (tmr_end) begin
          st_nxt = ST_IDLE;
          lock_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (sw_tmo && (st_r == ST_PROG || st_r == ST_ERASE || st_r == ST_CHIP)) begin
      tmo_nxt = 1'b1;
    end
    if (hold) begin
      st_nxt = ST_IDLE;
      tmr_nxt = TMR_ZERO;
      es_bg_nxt = 1'b0;
      asel_nxt = 1'b0;
      prot_req_nxt = 1'b0;
      if (!as_q2_r.hw_rst_n) begin
        otp_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      tmr_r <= TMR_ZERO;
      es_bg_r <= 1'b0;
      tmo_r <= 1'b0;
      otp_r <= 1'b0;
      lock_r <= 1'b0;
      asel_r <= 1'b0;
      ers_addr_r <= '0;
      prg_addr_r <= '0;
      prg_d7_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      es_bg_r <= es_bg_nxt;
      tmo_r <= tmo_nxt;
      otp_r <= otp_nxt;
      lock_r <= lock_nxt | lock_r;
      asel_r <= asel_nxt;
      ers_addr_r <= ers_addr_nxt;
      prg_addr_r <= prg_addr_nxt;
      prg_d7_r <= prg_d7_nxt;
    end
  end
  // Status word selection for the latched read address
  logic tog_r, tog2_r;
  wire logic erasing = st_r == ST_WIN || st_r == ST_ERASE || st_r == ST_ESP;
  wire logic programming = st_r == ST_PROG || st_r == ST_PSP;
  wire logic programming_hit = programming && prg_bank_hit;
  wire logic es_hit = (st_r == ST_ES || (es_bg_r && st_r != ST_IDLE)) && ers_blk_hit && !programming_hit;
  wire logic erase_hit = (erasing && ers_bank_hit) || st_r == ST_CHIP;
  wire logic ps_hit = st_r == ST_PS && prg_blk_hit;
  wire logic tog2_hit = (erase_hit && (ers_blk_hit || st_r == ST_CHIP)) || es_hit || ps_hit;
  wire logic is_stat = programming_hit || erase_hit || es_hit || ps_hit;
  wire logic [4:0] flags =
    programming_hit ? {!prg_d7_r, !tog_r, tmo_r, 1'b0, 1'b1} :
    erase_hit ? {1'b0, !tog_r, tmo_r, st_r != ST_WIN, tog2_hit ? !tog2_r : tog2_r} :
    es_hit ? {1'b1, 1'b1, 1'b0, 1'b0, !tog2_r} :
    {prg_d7_r, 1'b1, 1'b0, 1'b0, !tog2_r};
  logic [15:0] stat_w;
  always_comb begin
    stat_w = i_arr_data;
    stat_w[POLL_BIT] = flags[4];
    stat_w[TOG_BIT] = flags[3];
    stat_w[TMO_BIT] = flags[2];
    stat_w[WIN_BIT] = flags[1];
    stat_w[TOG2_BIT] = flags[0];
  end
  wire logic [15:0] lock_w = {15'h0000, lock_r} << LOCK_BIT;
  wire logic [15:0] first_w = is_stat ? stat_w : (asel_r && rd_otp) ? lock_w : i_arr_data;
  // Host read path; a status burst repeats its first word on every beat
  logic stat_hold_r;
  logic beat_pend_r;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_r <= '0;
      tog_r <= 1'b0;
      tog2_r <= 1'b0;
      stat_hold_r <= 1'b0;
      beat_pend_r <= 1'b0;
      o_adq <= 16'h0000;
      o_adq_oe <= 1'b0;
      o_arr_addr <= '0;
      o_arr_otp <= 1'b0;
      o_prot_req <= 1'b0;
      o_prot_blk <= 8'h00;
      o_bypass_en <= 1'b0;
    end else begin
      if (avd_lat) begin
        rd_addr_r <= pin_addr;
        o_arr_addr <= pin_addr;
      end else if (beat && !stat_hold_r) begin
        o_arr_addr <= o_arr_addr + 23'h000001;
      end
      o_arr_otp <= rd_otp;
      beat_pend_r <= beat && !stat_hold_r;
      if (rd_go) begin
        o_adq <= first_w;
        stat_hold_r <= is_stat;
        tog_r <= !tog_r;
        if (tog2_hit) begin
          tog2_r <= !tog2_r;
        end
      end else if (beat_pend_r) begin
        o_adq <= i_arr_data;
      end
      o_adq_oe <= !pin.ce_n && !pin.oe_n;
      o_prot_req <= prot_req_nxt;
      if (prot_req_nxt) begin
        o_prot_blk <= rd_addr_r[BLK_HI:BLK_LO];
      end
      o_bypass_en <= !otp_nxt && !hold;
    end
  end
endmodule
`default_nettype wire

// ### rtl/fsc_pkg.sv
// Constants, types and field layouts of the flash suspend/OTP/status controller
package fsc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int T_WIN_US = 50;
  localparam int T_ESUSP_US = 20;
  localparam int T_PSUSP_US = 2;
  localparam int T_LOCK_US = 100;
  localparam int WIN_CYC = T_WIN_US * CLK_MHZ;
  localparam int LOCK_CYC = T_LOCK_US * CLK_MHZ;
  localparam logic [13:0] ESUSP_CYC = 14'(T_ESUSP_US * CLK_MHZ);
  localparam logic [13:0] PSUSP_CYC = 14'(T_PSUSP_US * CLK_MHZ);
  localparam logic [13:0] TMR_ONE = 14'h0001;
  localparam logic [13:0] TMR_ZERO = 14'h0000;

  // Host-side commands (data byte of a write cycle)
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_OTP_ENTER = 8'h88;
  localparam logic [7:0] CMD_OTP_EXIT = 8'h8a;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROTECT = 8'h60;
  localparam logic [7:0] CMD_RESET = 8'hf0;

  // Word address fields
  localparam int ADDR_W = 23;
  localparam int BANK_HI = 22;
  localparam int BANK_LO = 19;
  localparam int BLK_HI = 22;
  localparam int BLK_LO = 15;
  localparam int OTP_LO = 7;
  localparam logic [15:0] OTP_TAG = 16'hffff;

  // Status bit positions on the data pins
  localparam int POLL_BIT = 7;
  localparam int TOG_BIT = 6;
  localparam int TMO_BIT = 5;
  localparam int WIN_BIT = 3;
  localparam int TOG2_BIT = 2;
  localparam int LOCK_BIT = 0;

  // Register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPADDR = 8'h04;
  localparam logic [7:0] REG_OPDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_BERASE = 1;
  localparam int CTRL_CERASE = 2;
  localparam int CTRL_DONE = 3;
  localparam int CTRL_TMO = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PROG = 4'h1,
    ST_WIN = 4'h2,
    ST_ERASE = 4'h3,
    ST_CHIP = 4'h4,
    ST_ESP = 4'h5,
    ST_ES = 4'h6,
    ST_PSP = 4'h7,
    ST_PS = 4'h8,
    ST_LOCK = 4'h9
  } fsc_state_e;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic avd_n;
    logic [6:0] addr_hi;
    logic [15:0] adq;
  } fsc_pins_s;

  typedef struct packed {
    fsc_pins_s pins;
    logic bclk;
    logic hw_rst_n;
    logic lockout;
  } fsc_async_s;
endpackage

// ### verif/fsc_ctrl_assertions.sv
// Checker of bus handshake, hold and pin drive relations of the controller
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl_assertions
  import fsc_pkg::*;
#(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Bus
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Pins and array side
  input wire fsc_pins_s i_pins,
  input wire logic i_hw_rst_n,
  input wire logic i_lockout,
  input wire logic o_adq_oe,
  input wire logic o_prot_req,
  input wire logic o_bypass_en,
  input wire logic o_arr_otp
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence take_s;
    i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  endsequence
  sequence rd_data_s;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  read_wait_a: assert property (take_s ##0 !i_hwrite |=> rd_data_s)
    else $error("read data phase length wrong");
  write_nowait_a: assert property (take_s ##0 i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  ready_short_a: assert property (!o_hreadyout |=> o_hreadyout)
    else $error("wait state longer than one cycle");
  resp_okay_a: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  prot_pulse_a: assert property (o_prot_req |=> !o_prot_req)
    else $error("protect request longer than one cycle");
  // Margin of two cycles over the sync lag keeps the four repeated-level checks quiet at edges
  hwrst_bypass_a: assert property (!i_hw_rst_n [*5] |-> !o_bypass_en)
    else $error("bypass allowed under hardware reset");
  held_noprot_a: assert property ((!i_hw_rst_n || i_lockout) [*5] |-> !o_prot_req)
    else $error("protect accepted while writes are held");
  otp_bypass_a: assert property (o_arr_otp |-> !$past(o_bypass_en))
    else $error("bypass allowed in otp mode");
  oe_quiet_a: assert property (i_pins.oe_n [*5] |-> !o_adq_oe)
    else $error("data driven with output enable high");
  ce_quiet_a: assert property (i_pins.ce_n [*5] |-> !o_adq_oe)
    else $error("data driven while deselected");
endmodule
bind fsc_ctrl fsc_ctrl_assertions #(.WIN_CYCLES(WIN_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_pins(i_pins),
  .i_hw_rst_n(i_hw_rst_n), .i_lockout(i_lockout), .o_adq_oe(o_adq_oe), .o_prot_req(o_prot_req),
  .o_bypass_en(o_bypass_en), .o_arr_otp(o_arr_otp));
`default_nettype wire

// ### verif/fsc_host_model.sv
// Host memory controller model driving the muxed pins and burst clock
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model
  import fsc_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Device read data
  input wire logic [15:0] i_adq,
  // Host pins and burst clock
  output fsc_pins_s o_pins,
  output logic o_bclk
);
  initial begin
    o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 7'h00, 16'h0000};
    o_bclk = 1'b0;
  end
  // Four clocks a level, one above the sync lag
  task automatic hold();
    repeat (4) @(posedge i_clk);
  endtask
  task automatic wr(input logic [22:0] a, input logic [7:0] d, input logic ce, input logic oe);
    @(posedge i_clk);
    o_pins <= '{ce, 1'b1, 1'b1, 1'b0, a[22:16], a[15:0]};
    hold();
    o_pins <= '{ce, 1'b1, oe, 1'b1, a[22:16], {8'h00, d}};
    hold();
    o_pins.we_n <= 1'b0;
    hold();
    o_pins.we_n <= 1'b1;
    hold();
    // Released lines show the inverse, never a stale copy
    o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a[22:16], ~{8'h00, d}};
    hold();
  endtask
  task automatic rd(input logic [22:0] a, input int beats, output logic [15:0] q0, output logic [15:0] q1);
    @(posedge i_clk);
    o_pins <= '{1'b0, 1'b1, 1'b1, 1'b0, a[22:16], a[15:0]};
    hold();
    o_pins <= '{1'b0, 1'b1, 1'b0, 1'b1, a[22:16], ~a[15:0]};
    hold();
    hold();
    q0 = i_adq;
    // Burst clock runs only inside the frame
    repeat (beats) begin
      #62.5 o_bclk = 1'b1;
      #62.5 o_bclk = 1'b0;
    end
    hold();
    hold();
    q1 = i_adq;
    @(posedge i_clk);
    o_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a[22:16], a[15:0]};
    hold();
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Top bench: bus and host-pin sequences against the controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsc_pkg::*;
;
  localparam logic [22:0] EB = 23'h100000;
  localparam logic [22:0] OB = 23'h400123;
  localparam logic [22:0] PB = 23'h200040;
  localparam logic [22:0] OA = 23'h7fff80;
  logic i_clk, i_nrst, hsel, hwrite, hw_rst_n, lockout, hrdy, hresp, adq_oe, arr_otp, prot_req, bypass, bclk, otp_seen;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, s;
  logic [15:0] adq, q0, q1;
  logic [22:0] arr_addr;
  logic [7:0] prot_blk, blk_seen;
  fsc_pins_s pins;
  wire logic [15:0] arr_data = arr_addr[15:0] ^ 16'h3c3c;
  int n_fail, cmp_count;
  fsc_ctrl #(.WIN_CYCLES(300), .LOCK_CYCLES(60)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_pins(pins), .i_burst_clk(bclk), .i_hw_rst_n(hw_rst_n), .i_lockout(lockout), .o_adq(adq),
    .o_adq_oe(adq_oe), .o_arr_addr(arr_addr), .o_arr_otp(arr_otp), .i_arr_data(arr_data),
    .o_prot_req(prot_req), .o_prot_blk(prot_blk), .o_bypass_en(bypass));
  fsc_host_model host (.i_clk(i_clk), .i_adq(adq), .o_pins(pins), .o_bclk(bclk));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      otp_seen <= 1'b0;
      blk_seen <= 8'h00;
    end else begin
      if (arr_otp) otp_seen <= 1'b1;
      if (prot_req) blk_seen <= prot_blk;
    end
  end
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic ab(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    s = hrdata;
  endtask
  task automatic cw(input int b);
    ab(1'b1, REG_CTRL, 32'h1 << b);
  endtask
  task automatic st(input logic [3:0] e);
    ab(1'b0, REG_STAT, 32'h0);
    chk("state", {12'h0, e}, {12'h0, s[3:0]});
  endtask
  task automatic sb(input int b, input logic e);
    ab(1'b0, REG_STAT, 32'h0);
    chk("stat bit", {15'h0, e}, {15'h0, s[b]});
  endtask
  task automatic hrst();
    hw_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    hw_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    conclude();
  end
  initial begin
    {i_nrst, hsel, hwrite, htrans, haddr, hwdata, lockout} = '0;
    hw_rst_n = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    hw_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    st(ST_IDLE);
    chk("bypass", 16'h1, {15'h0, bypass});
    host.wr(EB, CMD_SUSPEND, 1'b0, 1'b1);
    st(ST_IDLE);
    host.wr(EB, CMD_RESUME, 1'b0, 1'b1);
    st(ST_IDLE);
    ab(1'b1, REG_OPADDR, {9'h0, EB});
    cw(CTRL_BERASE);
    st(ST_WIN);
    host.wr(OB, CMD_SUSPEND, 1'b0, 1'b1);
    st(ST_ES);
    host.rd(EB, 0, q0, q1);
    chk("esusp flags", 16'h00c0, q0 & 16'h00e8);
    host.wr(OB, CMD_PROTECT, 1'b0, 1'b1);
    chk("protect blk", {8'h0, OB[22:15]}, {8'h0, blk_seen});
    host.wr(23'h0, CMD_RESUME, 1'b0, 1'b1);
    st(ST_ERASE);
    host.wr(23'h0, CMD_SUSPEND, 1'b0, 1'b1);
    st(ST_ESP);
    host.rd(OB, 0, q0, q1);
    chk("other bank", OB[15:0] ^ 16'h3c3c, q0);
    repeat (2000) @(posedge i_clk);
    st(ST_ES);
    ab(1'b1, REG_OPADDR, {9'h0, PB});
    ab(1'b1, REG_OPDATA, 32'h0080);
    cw(CTRL_PROG);
    sb(4, 1'b1);
    host.rd(PB, 0, q0, q1);
    chk("es prog flags", 16'h0004, q0 & 16'h00ad);
    cw(CTRL_DONE);
    st(ST_ES);
    host.wr(OB, CMD_AUTOSEL, 1'b0, 1'b1);
    sb(7, 1'b1);
    host.wr(OB, CMD_RESUME, 1'b0, 1'b1);
    st(ST_ERASE);
    cw(CTRL_DONE);
    host.wr(OB, CMD_RESET, 1'b0, 1'b1);
    cw(CTRL_CERASE);
    host.wr(EB, CMD_SUSPEND, 1'b0, 1'b1);
    st(ST_CHIP);
    host.rd(EB, 0, q0, q1);
    chk("erase flags", 16'h0008, q0 & 16'h00a8);
    cw(CTRL_DONE);
    cw(CTRL_PROG);
    st(ST_PROG);
    host.rd(PB, 2, q0, q1);
    chk("prog flags", 16'h0004, q0 & 16'h00ad);
    chk("burst beat", 16'h0004, q1 & 16'h00ad);
    host.rd(PB, 0, q1, q1);
    chk("toggle", {15'h0, ~q0[6]}, {15'h0, q1[6]});
    host.wr(OA, CMD_OTP_ENTER, 1'b0, 1'b1);
    sb(5, 1'b0);
    host.wr(EB, CMD_SUSPEND, 1'b0, 1'b1);
    st(ST_PSP);
    host.rd(OB, 0, q0, q1);
    chk("rww read", OB[15:0] ^ 16'h3c3c, q0);
    repeat (200) @(posedge i_clk);
    st(ST_PS);
    host.wr(EB, CMD_RESUME, 1'b0, 1'b1);
    st(ST_PROG);
    cw(CTRL_TMO);
    host.rd(PB, 0, q0, q1);
    chk("timeout flags", 16'h0020, q0 & 16'h00a9);
    cw(CTRL_DONE);
    host.rd(PB, 1, q0, q1);
    chk("true data", PB[15:0] ^ 16'h3c3c, q0);
    chk("burst next", (PB[15:0] + 16'h0001) ^ 16'h3c3c, q1);
    cw(CTRL_BERASE);
    host.wr(EB, CMD_RESET, 1'b0, 1'b1);
    st(ST_IDLE);
    cw(CTRL_BERASE);
    repeat (310) @(posedge i_clk);
    st(ST_ERASE);
    host.wr(EB, CMD_SUSPEND, 1'b0, 1'b0);
    st(ST_ERASE);
    host.wr(EB, CMD_SUSPEND, 1'b1, 1'b1);
    st(ST_ERASE);
    lockout <= 1'b1;
    repeat (6) @(posedge i_clk);
    sb(10, 1'b1);
    st(ST_IDLE);
    host.wr(OA, CMD_OTP_ENTER, 1'b0, 1'b1);
    sb(5, 1'b0);
    lockout <= 1'b0;
    repeat (6) @(posedge i_clk);
    host.rd(OA, 0, q0, q1);
    chk("otp map off", 16'h0, {15'h0, otp_seen});
    host.wr(OA, CMD_OTP_ENTER, 1'b0, 1'b1);
    chk("bypass", 16'h0, {15'h0, bypass});
    host.rd(OA, 0, q0, q1);
    chk("otp map", 16'h1, {15'h0, otp_seen});
    host.wr(OA, CMD_AUTOSEL, 1'b0, 1'b1);
    host.rd(OA, 0, q0, q1);
    chk("lock bit", 16'h0, {15'h0, q0[0]});
    host.wr(OA, CMD_PROTECT, 1'b0, 1'b1);
    st(ST_LOCK);
    hrst();
    ab(1'b0, REG_STAT, 32'h0);
    chk("otp after rst", 16'h0, {14'h0, s[6:5]});
    host.wr(OA, CMD_OTP_ENTER, 1'b0, 1'b1);
    host.wr(OA, CMD_PROTECT, 1'b0, 1'b1);
    repeat (70) @(posedge i_clk);
    sb(6, 1'b1);
    host.wr(OA, CMD_AUTOSEL, 1'b0, 1'b1);
    host.rd(OA, 0, q0, q1);
    chk("lock bit", 16'h1, {15'h0, q0[0]});
    host.wr(OA, CMD_OTP_EXIT, 1'b0, 1'b1);
    sb(5, 1'b0);
    chk("bypass", 16'h1, {15'h0, bypass});
    conclude();
  end
endmodule
`default_nettype wire
